/* File: hdl/gx_consts.svh */
`ifndef GX_CONSTS_SVH
`define GX_CONSTS_SVH

// ----------------------------------------
// Device registers, bus and interrupt constants
// ----------------------------------------
`define GX_REG_INPUT 2'h0
`define GX_REG_OUTPUT 2'h1
`define GX_REG_INVERT 2'h2
`define GX_REG_DIR 2'h3
`define GX_RST_OUTPUT 8'hFF
`define GX_RST_INVERT 8'h00
`define GX_RST_DIR 8'hFF
`define GX_ADDR_PREFIX_LO 4'h4
`define GX_ADDR_PREFIX_HI 4'h7
`define GX_RX_BITS 4'h8
`define GX_TX_LAST 4'h7
`define GX_INT_HOLD 3'h5

// ----------------------------------------
// Host registers and timing
// ----------------------------------------
`define GX_H_CTRL 3'h0
`define GX_H_DEV 3'h1
`define GX_H_CMD 3'h2
`define GX_H_WDATA 3'h3
`define GX_H_STATUS 3'h4
`define GX_H_RDATA 3'h5
`define GX_OP_NONE 2'h0
`define GX_OP_WRITE 2'h1
`define GX_OP_READ 2'h2
`define GX_OP_READ_CUR 2'h3
`define GX_RST_DEV 7'h20
`define GX_CLK_NS 20
`define GX_SCL_QTR_NS 1250
`define GX_SCL_QTR_CYC (`GX_SCL_QTR_NS / `GX_CLK_NS)
`define GX_QTR_MIN 8

`endif

/* File: hdl/gx_device.sv */
`timescale 1ns/1ns
`include "gx_consts.svh"

// Notes on behaviour
// R1 - Answer prefix plus three address pins
// R2 - Direction bit one reads, zero writes
// R3 - First written byte loads hidden pointer
// R4 - Pointer low bits pick one register
// R5 - Input register shows every pin level
// R6 - Writes to input register are dropped
// R7 - Output register reads back latch value
// R8 - Latch drives pin only when output
// R9 - Inversion bit flips sensed input level
// R10 - Direction one input, zero driven output
// R11 - Reset loads defaults, bus goes idle
// R12 - Input pin edge asserts interrupt low
// R13 - Interrupt clears on restore or read
// R14 - Read clear at acknowledge clock rise
// R15 - Output pins never raise interrupt
// R16 - Later changes raise interrupt again
// R17 - Write: address, command, then data
// R18 - Read: command, restart, address read
// R19 - Master does not acknowledge last
// R20 - Pins captured at acknowledge clock rise
// R21 - Read without command uses old pointer
// R22 - Stop ends transfer, writes kept
// R23 - Pointer never advances by itself
// R24 - Line and pin inputs are synchronised
module gx_device #(
  parameter logic [3:0] ADDR_PREFIX = `GX_ADDR_PREFIX_LO
) (
  input wire logic clock,
  input wire logic rst,
  gx_link_if.dev link,
  input wire gx_pkg::gx_byte_t port_i,
  output gx_pkg::gx_byte_t port_o,
  output gx_pkg::gx_byte_t port_oe_n,
  input wire logic addr_sel_high,
  input wire logic addr_sel_mid,
  input wire logic addr_sel_low
);
  import gx_pkg::*;

  if (ADDR_PREFIX != `GX_ADDR_PREFIX_LO && ADDR_PREFIX != `GX_ADDR_PREFIX_HI) begin : g_chk
    $error("gx_device address prefix is not a known variant");
  end

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [12:0] syn;
  logic scl_q;
  logic sda_q;
  logic [2:0] sel_q;
  gx_byte_t pin_q;

  gx_sync #(
    .W(13),
    .RST_VAL(13'h1FFF)
  ) u_sync (
    .clock(clock),
    .rst(rst),
    .d({link.scl, link.sda, addr_sel_high, addr_sel_mid, addr_sel_low, port_i}),
    .q(syn)
  ); // R24

  assign scl_q = syn[12];
  assign sda_q = syn[11];
  assign sel_q = syn[10:8];
  assign pin_q = syn[7:0];

  // ----------------------------------------
  // Bus condition detection
  // ----------------------------------------
  logic scl_prev_ff;
  logic sda_prev_ff;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end else begin
      scl_prev_ff <= scl_q;
      sda_prev_ff <= sda_q;
    end
  end

  assign scl_rise = scl_q & ~scl_prev_ff;
  assign scl_fall = ~scl_q & scl_prev_ff;
  assign start_seen = scl_q & scl_prev_ff & sda_prev_ff & ~sda_q;
  assign stop_seen = scl_q & scl_prev_ff & ~sda_prev_ff & sda_q;

  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  gx_dev_st_e st_ff;
  gx_role_e role_ff;
  logic [3:0] bit_cnt_ff;
  gx_byte_t shift_ff;
  logic rw_ff;
  logic mack_ff;
  logic sda_oe_n_ff;
  gx_byte_t ptr_ff;
  gx_byte_t out_latch_ff;
  gx_byte_t inv_ff;
  gx_byte_t dir_ff;
  gx_byte_t in_snap_ff;
  gx_byte_t int_ref_ff;
  logic [2:0] init_cnt_ff;
  logic int_oe_n_ff;
  gx_byte_t rd_val;
  logic addr_hit;
  logic byte_done;
  logic wr_hit;
  logic ptr_hit;
  logic ack_rise;
  logic int_clr;

  assign addr_hit = (shift_ff[7:1] == {ADDR_PREFIX, sel_q}); // R1
  assign byte_done = (st_ff == dev_rx) && scl_fall && (bit_cnt_ff == `GX_RX_BITS);
  assign wr_hit = byte_done && (role_ff == role_data);
  assign ptr_hit = byte_done && (role_ff == role_cmd);
  assign ack_rise = scl_rise && ((st_ff == dev_rx_ack) || (st_ff == dev_tx_ack));
  assign int_clr = scl_rise && (st_ff == dev_tx_ack) && (ptr_ff[1:0] == `GX_REG_INPUT); // R14

  // Selected register for transmit
  always_comb begin
    unique case (ptr_ff[1:0]) // R4 R21
      `GX_REG_INPUT: rd_val = in_snap_ff ^ (inv_ff & dir_ff); // R5 R9
      `GX_REG_OUTPUT: rd_val = out_latch_ff; // R7
      `GX_REG_INVERT: rd_val = inv_ff;
      `GX_REG_DIR: rd_val = dir_ff;
    endcase
  end

  // ----------------------------------------
  // Serial protocol engine
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin // R11
      st_ff <= dev_idle;
      role_ff <= role_addr;
      bit_cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      rw_ff <= 1'b0;
      mack_ff <= 1'b0;
      sda_oe_n_ff <= 1'b1;
    end else if (start_seen) begin
      st_ff <= dev_rx;
      role_ff <= role_addr;
      bit_cnt_ff <= 4'h0;
      sda_oe_n_ff <= 1'b1;
    end else if (stop_seen) begin // R22
      st_ff <= dev_idle;
      sda_oe_n_ff <= 1'b1;
    end else begin
      unique case (st_ff)
        dev_idle, dev_skip: begin
          sda_oe_n_ff <= 1'b1;
        end
        dev_rx: begin
          if (scl_rise) begin
            shift_ff <= {shift_ff[6:0], sda_q};
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end else if (byte_done) begin
            if (role_ff == role_addr && !addr_hit) begin
              st_ff <= dev_skip;
            end else begin
              st_ff <= dev_rx_ack;
              sda_oe_n_ff <= 1'b0;
              if (role_ff == role_addr) begin
                rw_ff <= shift_ff[0]; // R2
              end
            end
          end
        end
        dev_rx_ack: begin
          if (scl_fall) begin
            bit_cnt_ff <= 4'h0;
            if (role_ff == role_addr && rw_ff) begin
              st_ff <= dev_tx; // R18
              shift_ff <= rd_val;
              sda_oe_n_ff <= rd_val[7];
            end else begin
              st_ff <= dev_rx;
              sda_oe_n_ff <= 1'b1;
              role_ff <= (role_ff == role_addr) ? role_cmd : role_data; // R17
            end
          end
        end
        dev_tx: begin
          if (scl_fall) begin
            if (bit_cnt_ff == `GX_TX_LAST) begin
              st_ff <= dev_tx_ack;
              sda_oe_n_ff <= 1'b1;
            end else begin
              shift_ff <= {shift_ff[6:0], 1'b0};
              sda_oe_n_ff <= shift_ff[6];
              bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end
          end
        end
        dev_tx_ack: begin
          if (scl_rise) begin
            mack_ff <= ~sda_q;
          end else if (scl_fall) begin
            if (mack_ff) begin // R19
              st_ff <= dev_tx;
              shift_ff <= rd_val;
              sda_oe_n_ff <= rd_val[7];
              bit_cnt_ff <= 4'h0;
            end else begin
              st_ff <= dev_skip;
            end
          end
        end
        default: begin
          st_ff <= dev_idle;
          sda_oe_n_ff <= 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Command pointer
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ptr_ff <= 8'h00;
    end else if (ptr_hit) begin
      ptr_ff <= shift_ff; // R3 R23
    end
  end

  // ----------------------------------------
  // Port configuration registers
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin // R11
      out_latch_ff <= `GX_RST_OUTPUT;
      inv_ff <= `GX_RST_INVERT;
      dir_ff <= `GX_RST_DIR;
    end else if (wr_hit) begin // R22 R23
      unique case (ptr_ff[1:0])
        `GX_REG_INPUT: ; // R6
        `GX_REG_OUTPUT: out_latch_ff <= shift_ff;
        `GX_REG_INVERT: inv_ff <= shift_ff;
        `GX_REG_DIR: dir_ff <= shift_ff;
      endcase
    end
  end

  // ----------------------------------------
  // Input capture and interrupt
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      in_snap_ff <= 8'h00;
    end else if (ack_rise) begin
      in_snap_ff <= pin_q; // R20
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      init_cnt_ff <= `GX_INT_HOLD;
      int_ref_ff <= 8'h00;
    end else begin
      init_cnt_ff <= (init_cnt_ff == 3'h0) ? 3'h0 : init_cnt_ff - 3'h1;
      if ((init_cnt_ff != 3'h0) || int_clr) begin
        int_ref_ff <= pin_q; // R13
      end
    end
  end

  // Level compare: restore clears, later change re-arms; quiet until pins synchronised
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      int_oe_n_ff <= 1'b1;
    end else begin
      int_oe_n_ff <= ~(|((pin_q ^ int_ref_ff) & dir_ff)) | (init_cnt_ff != 3'h0); // R12 R13 R15 R16
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign port_o = out_latch_ff; // R8
  assign port_oe_n = dir_ff; // R10
  assign link.sda_dev_o = 1'b0;
  assign link.sda_dev_oe_n = sda_oe_n_ff;
  assign link.int_o = 1'b0;
  assign link.int_oe_n = int_oe_n_ff;
endmodule

/* File: hdl/gx_host.sv */
`timescale 1ns/1ns
`include "gx_consts.svh"
module gx_host #(
  parameter int QTR_CYC = `GX_SCL_QTR_CYC
) (
  input wire logic clock,
  input wire logic rst,
  gx_link_if.host link,
  input wire gx_pkg::gx_haddr_t reg_addr,
  input wire gx_pkg::gx_byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output gx_pkg::gx_byte_t reg_rdata
);
  import gx_pkg::*;

  if (QTR_CYC < `GX_QTR_MIN || QTR_CYC > 65535) begin : g_chk
    $error("gx_host quarter period out of range");
  end

  // ----------------------------------------
  // Line inputs
  // ----------------------------------------
  logic [1:0] syn;
  gx_sync #(
    .W(2),
    .RST_VAL(2'h3)
  ) u_sync (
    .clock(clock),
    .rst(rst),
    .d({link.sda, link.int_n}),
    .q(syn)
  );

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  logic [6:0] dev_ff;
  gx_byte_t cmd_ff;
  gx_byte_t wdata_ff;
  logic [1:0] op_ff;
  logic busy_ff;
  logic nack_ff;
  gx_byte_t rdata_ff;
  logic go;

  assign go = reg_wr && (reg_addr == `GX_H_CTRL) && !busy_ff && syn[1]
              && (reg_wdata[1:0] != `GX_OP_NONE); // R22

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dev_ff <= `GX_RST_DEV;
      cmd_ff <= 8'h00;
      wdata_ff <= 8'h00;
    end else if (reg_wr && !busy_ff) begin
      unique case (reg_addr)
        `GX_H_DEV: dev_ff <= reg_wdata[6:0];
        `GX_H_CMD: cmd_ff <= reg_wdata;
        `GX_H_WDATA: wdata_ff <= reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `GX_H_DEV: reg_rdata <= {1'b0, dev_ff};
        `GX_H_CMD: reg_rdata <= cmd_ff;
        `GX_H_WDATA: reg_rdata <= wdata_ff;
        `GX_H_STATUS: reg_rdata <= {5'h00, ~syn[0], nack_ff, busy_ff};
        `GX_H_RDATA: reg_rdata <= rdata_ff;
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ----------------------------------------
  // Quarter-period divider
  // ----------------------------------------
  logic [15:0] div_ff;
  logic tick;
  assign tick = (div_ff == 16'(QTR_CYC - 1));

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      div_ff <= 16'h0000;
    end else if (!busy_ff || tick) begin
      div_ff <= 16'h0000;
    end else begin
      div_ff <= div_ff + 16'h0001;
    end
  end

  // ----------------------------------------
  // Transfer sequencer
  // ----------------------------------------
  gx_host_st_e st_ff;
  logic [1:0] q_ff;
  logic [1:0] seq_ff;
  logic [3:0] bit_cnt_ff;
  gx_byte_t shift_ff;
  logic ack_ff;
  logic scl_oe_n_ff;
  logic sda_oe_n_ff;

  // Byte sent in each step of the sequence
  function automatic gx_byte_t tx_byte(input logic [1:0] s);
    unique case (s)
      2'h0: tx_byte = {dev_ff, 1'b0};
      2'h1: tx_byte = cmd_ff;
      2'h2: tx_byte = (op_ff == `GX_OP_WRITE) ? wdata_ff : {dev_ff, 1'b1}; // R2 R17
      default: tx_byte = 8'hFF;
    endcase
  endfunction

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_ff <= hs_idle;
      q_ff <= 2'h0;
      seq_ff <= 2'h0;
      bit_cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      ack_ff <= 1'b1;
      op_ff <= `GX_OP_NONE;
      busy_ff <= 1'b0;
      nack_ff <= 1'b0;
      rdata_ff <= 8'h00;
      scl_oe_n_ff <= 1'b1;
      sda_oe_n_ff <= 1'b1;
    end else if (go) begin
      busy_ff <= 1'b1;
      nack_ff <= 1'b0;
      op_ff <= reg_wdata[1:0];
      st_ff <= hs_start;
      q_ff <= 2'h0;
      seq_ff <= (reg_wdata[1:0] == `GX_OP_READ_CUR) ? 2'h2 : 2'h0; // R21
    end else if (busy_ff && tick) begin
      q_ff <= q_ff + 2'h1;
      unique case (st_ff)
        hs_start: begin
          unique case (q_ff)
            2'h0: sda_oe_n_ff <= 1'b1;
            2'h1: scl_oe_n_ff <= 1'b1;
            2'h2: sda_oe_n_ff <= 1'b0;
            2'h3: begin
              scl_oe_n_ff <= 1'b0;
              st_ff <= hs_bit;
              bit_cnt_ff <= 4'h0;
              shift_ff <= tx_byte(seq_ff);
            end
          endcase
        end
        hs_bit: begin
          unique case (q_ff)
            2'h0: sda_oe_n_ff <= (bit_cnt_ff == `GX_RX_BITS || seq_ff == 2'h3) ? 1'b1 : shift_ff[7]; // R19
            2'h1: scl_oe_n_ff <= 1'b1;
            2'h2: begin
              if (bit_cnt_ff == `GX_RX_BITS) begin
                ack_ff <= syn[1];
              end else begin
                shift_ff <= {shift_ff[6:0], syn[1]};
              end
            end
            2'h3: begin
              scl_oe_n_ff <= 1'b0;
              bit_cnt_ff <= bit_cnt_ff + 4'h1;
              if (bit_cnt_ff == `GX_RX_BITS) begin
                bit_cnt_ff <= 4'h0;
                if (seq_ff != 2'h3 && ack_ff) begin
                  nack_ff <= 1'b1;
                  st_ff <= hs_stop;
                end else if (seq_ff == 2'h3) begin
                  rdata_ff <= shift_ff;
                  st_ff <= hs_stop;
                end else if (op_ff == `GX_OP_WRITE && seq_ff == 2'h2) begin
                  st_ff <= hs_stop;
                end else if (op_ff == `GX_OP_READ && seq_ff == 2'h1) begin
                  seq_ff <= 2'h2;
                  st_ff <= hs_start; // R18
                end else begin
                  seq_ff <= seq_ff + 2'h1;
                  shift_ff <= tx_byte(seq_ff + 2'h1);
                end
              end
            end
          endcase
        end
        hs_stop: begin
          unique case (q_ff)
            2'h0: sda_oe_n_ff <= 1'b0;
            2'h1: scl_oe_n_ff <= 1'b1;
            2'h2: sda_oe_n_ff <= 1'b1; // R22
            2'h3: begin
              busy_ff <= 1'b0;
              st_ff <= hs_idle;
            end
          endcase
        end
        hs_idle: ;
      endcase
    end
  end

  assign link.scl_o = 1'b0;
  assign link.scl_oe_n = scl_oe_n_ff;
  assign link.sda_host_o = 1'b0;
  assign link.sda_host_oe_n = sda_oe_n_ff;
endmodule

/* File: hdl/gx_link_if.sv */
`timescale 1ns/1ns
interface gx_link_if;
  logic scl_o;
  logic scl_oe_n;
  logic sda_host_o;
  logic sda_host_oe_n;
  logic sda_dev_o;
  logic sda_dev_oe_n;
  logic int_o;
  logic int_oe_n;
  logic scl;
  logic sda;
  logic int_n;

  // ----------------------------------------
  // Wired lines with pull-ups
  // ----------------------------------------
  assign scl = scl_oe_n | scl_o;
  assign sda = (sda_host_oe_n | sda_host_o) & (sda_dev_oe_n | sda_dev_o);
  assign int_n = int_oe_n | int_o;

  modport dev (
    input scl,
    input sda,
    output sda_dev_o,
    output sda_dev_oe_n,
    output int_o,
    output int_oe_n
  );
  modport host (
    output scl_o,
    output scl_oe_n,
    output sda_host_o,
    output sda_host_oe_n,
    input sda,
    input int_n
  );
endinterface

/* File: hdl/gx_pkg.sv */
package gx_pkg;
  typedef logic [7:0] gx_byte_t;
  typedef logic [2:0] gx_haddr_t;
  typedef enum logic [2:0] {
    dev_idle = 3'h0,
    dev_rx = 3'h1,
    dev_rx_ack = 3'h2,
    dev_tx = 3'h3,
    dev_tx_ack = 3'h4,
    dev_skip = 3'h5
  } gx_dev_st_e;
  typedef enum logic [1:0] {
    role_addr = 2'h0,
    role_cmd = 2'h1,
    role_data = 2'h2
  } gx_role_e;
  typedef enum logic [1:0] {
    hs_idle = 2'h0,
    hs_start = 2'h1,
    hs_bit = 2'h2,
    hs_stop = 2'h3
  } gx_host_st_e;
endpackage

/* File: hdl/gx_sync.sv */
`timescale 1ns/1ns
module gx_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = {W{1'b1}}
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;

  if (W < 1) begin : g_chk
    $error("gx_sync width must be at least one");
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s1_ff <= RST_VAL;
      s2_ff <= RST_VAL;
      s3_ff <= RST_VAL;
    end else begin
      s1_ff <= d;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Take a new level only once stages two and three agree
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q <= RST_VAL;
    end else begin
      q <= (~(s2_ff ^ s3_ff) & s2_ff) | ((s2_ff ^ s3_ff) & q);
    end
  end
endmodule

/* File: sim/gx_link_checker.sv */
`timescale 1ns/1ns
module gx_link_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_dev_oe_n,
  input wire logic int_oe_n,
  input wire gx_pkg::gx_byte_t port_i,
  input wire gx_pkg::gx_byte_t port_o,
  input wire gx_pkg::gx_byte_t port_oe_n
);
  import gx_pkg::*;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // ----------------------------------------
  // Reset and interrupt
  // ----------------------------------------
  a_int_reset_quiet: assert property ($fell(rst) |-> int_oe_n [*2])
    else $error("interrupt active right after reset");
  a_reset_defaults: assert property ($fell(rst) |-> port_o == 8'hFF && port_oe_n == 8'hFF && sda_dev_oe_n)
    else $error("register defaults wrong after reset");
  a_int_on_edge: assert property ((int_oe_n && $changed(port_i & port_oe_n) && $stable(port_oe_n))
    ##1 $stable(port_i) [*8] |-> !int_oe_n)
    else $error("input edge raised no interrupt");
  a_outputs_no_irq: assert property ((port_oe_n == 8'h00) [*8] |-> int_oe_n)
    else $error("interrupt with all pins outputs");

  // ----------------------------------------
  // Serial line
  // ----------------------------------------
  a_dev_sda_scl_low: assert property ($changed(sda_dev_oe_n) |-> !scl)
    else $error("device moved data while clock high");
  a_drive_held_high: assert property ($rose(scl) && !sda_dev_oe_n |-> !sda_dev_oe_n [*8])
    else $error("device released data during clock high");
  a_start_dev_quiet: assert property ($fell(sda) && scl |-> sda_dev_oe_n)
    else $error("device drove data at start");
  a_stop_releases: assert property ($rose(sda) && scl |-> sda_dev_oe_n [*8])
    else $error("device drove data after stop");
endmodule

/* File: sim/i2c_gpio_expander_8bit_bench.sv */
`timescale 1ns/1ns
`include "gx_consts.svh"
module i2c_gpio_expander_8bit_bench;
  import gx_pkg::*;
  typedef struct {logic [1:0] op; gx_byte_t cmd; gx_byte_t wd; gx_byte_t exp;} gx_row_s;
  logic clock = 1'b0;
  logic rst = 1'b1;
  gx_haddr_t reg_addr = 3'h0;
  gx_byte_t reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  gx_byte_t reg_rdata;
  gx_byte_t port_o;
  gx_byte_t port_oe_n;
  gx_byte_t ext_lvl = 8'h3C;
  gx_byte_t port_i;
  logic [2:0] addr_pins = 3'h5;
  int n_errors = 0;
  int samples_checked = 0;
  gx_byte_t st;
  gx_byte_t v;
  gx_row_s rows [14] = '{
    '{`GX_OP_READ, 8'h01, 8'h00, 8'hFF},
    '{`GX_OP_READ, 8'h02, 8'h00, 8'h00},
    '{`GX_OP_READ, 8'h03, 8'h00, 8'hFF},
    '{`GX_OP_WRITE, 8'h01, 8'hA5, 8'h00},
    '{`GX_OP_READ, 8'h01, 8'h00, 8'hA5},
    '{`GX_OP_WRITE, 8'h03, 8'hF0, 8'h00},
    '{`GX_OP_READ, 8'h03, 8'h00, 8'hF0},
    '{`GX_OP_WRITE, 8'h00, 8'h55, 8'h00},
    '{`GX_OP_READ, 8'h01, 8'h00, 8'hA5},
    '{`GX_OP_WRITE, 8'h06, 8'h10, 8'h00},
    '{`GX_OP_READ, 8'h02, 8'h00, 8'h10},
    '{`GX_OP_READ, 8'h06, 8'h00, 8'h10},
    '{`GX_OP_READ, 8'h00, 8'h00, 8'h25},
    '{`GX_OP_READ_CUR, 8'h00, 8'h00, 8'h25}
  };

  // ----------------------------------------
  // Pins: driven by device when output
  // ----------------------------------------
  assign port_i = (port_o & ~port_oe_n) | (ext_lvl & port_oe_n);

  gx_link_if link_bus ();
  gx_device #(.ADDR_PREFIX(`GX_ADDR_PREFIX_HI)) gx_device_inst (
    .clock(clock), .rst(rst), .link(link_bus), .port_i(port_i), .port_o(port_o),
    .port_oe_n(port_oe_n), .addr_sel_high(addr_pins[2]), .addr_sel_mid(addr_pins[1]),
    .addr_sel_low(addr_pins[0])
  );
  gx_host #(.QTR_CYC(8)) gx_host_inst (
    .clock(clock), .rst(rst), .link(link_bus), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
  );
  gx_link_checker gx_link_checker_inst (
    .clock(clock), .rst(rst), .scl(link_bus.scl), .sda(link_bus.sda),
    .sda_dev_oe_n(link_bus.sda_dev_oe_n), .int_oe_n(link_bus.int_oe_n),
    .port_i(port_i), .port_o(port_o), .port_oe_n(port_oe_n)
  );

  always #10 clock = ~clock;

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk8(input gx_byte_t got, input gx_byte_t exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic hwr(input gx_haddr_t a, input gx_byte_t d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask

  task automatic hrd(input gx_haddr_t a, output gx_byte_t d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clock);
  endtask

  task automatic xfer(input logic [1:0] op, input gx_byte_t cmd, input gx_byte_t wd);
    int k;
    hwr(`GX_H_CMD, cmd);
    hwr(`GX_H_WDATA, wd);
    hwr(`GX_H_CTRL, {6'h00, op});
    for (k = 0; k < 4000; k++) begin
      hrd(`GX_H_STATUS, st);
      if (st[0] === 1'b0) break;
    end
    chk8(st & 8'h01, 8'h00);
  endtask

  task automatic irq_chk(input gx_byte_t exp);
    repeat (20) @(posedge clock);
    hrd(`GX_H_STATUS, st);
    chk8(st & 8'h04, exp);
  endtask

  task automatic tally_and_finish();
    $display("checked %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  initial begin
    repeat (80000) @(posedge clock);
    n_errors++;
    tally_and_finish();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    repeat (5) @(posedge clock);
    hwr(`GX_H_DEV, 8'h3D);
    for (int i = 0; i < 14; i++) begin
      xfer(rows[i].op, rows[i].cmd, rows[i].wd);
      chk8(st & 8'h02, 8'h00);
      if (rows[i].op != `GX_OP_WRITE) begin
        hrd(`GX_H_RDATA, v);
        chk8(v, rows[i].exp);
      end
    end
    chk8(port_oe_n, 8'hF0);
    chk8(port_o & ~port_oe_n, 8'h05);
    irq_chk(8'h00);
    ext_lvl <= 8'hBC;
    irq_chk(8'h04);
    ext_lvl <= 8'h3C;
    irq_chk(8'h00);
    ext_lvl <= 8'h1C;
    irq_chk(8'h04);
    xfer(`GX_OP_READ_CUR, 8'h00, 8'h00);
    hrd(`GX_H_RDATA, v);
    chk8(v, 8'h05);
    irq_chk(8'h00);
    ext_lvl <= 8'h3C;
    irq_chk(8'h04);
    ext_lvl <= 8'h13;
    irq_chk(8'h00);
    xfer(`GX_OP_WRITE, 8'h03, 8'h00);
    irq_chk(8'h00);
    hwr(`GX_H_DEV, 8'h25);
    xfer(`GX_OP_WRITE, 8'h01, 8'h00);
    chk8(st & 8'h02, 8'h02);
    hwr(`GX_H_DEV, 8'h3C);
    xfer(`GX_OP_WRITE, 8'h01, 8'h00);
    chk8(st & 8'h02, 8'h02);
    chk8(port_o, 8'hA5);
    rst <= 1'b1;
    addr_pins <= 3'h2;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    repeat (5) @(posedge clock);
    chk8(port_oe_n, 8'hFF);
    chk8(port_o, 8'hFF);
    irq_chk(8'h00);
    hwr(`GX_H_DEV, 8'h3A);
    xfer(`GX_OP_READ, 8'h00, 8'h00);
    chk8(st & 8'h02, 8'h00);
    hrd(`GX_H_RDATA, v);
    chk8(v, 8'h13);
    tally_and_finish();
  end
endmodule
